/* pss_pkg.sv */
// shared constants and carriers for the program sequencer
package pss_pkg;
	// register map, byte addresses on the axi4-lite slave
	localparam int unsigned ADDR_W   = 4;
	localparam logic [3:0]  ADDR_PCL = 4'h0;
	localparam logic [3:0]  ADDR_CTL = 4'h4;
	localparam logic [3:0]  ADDR_STA = 4'h8;
	// control register fields and reset value
	localparam int unsigned CTL_RC_BIT  = 0;
	localparam int unsigned CTL_EXT_BIT = 1;
	localparam int unsigned CTL_TMR_BIT = 2;
	localparam logic [2:0]  CTL_RESET   = 3'h0;
	// status register fields
	localparam int unsigned STA_EXEC_BIT  = 16;
	localparam int unsigned STA_PHASE_LSB = 24;
	// axi response codes
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// special program addresses
	localparam logic [10:0] VEC_RESET = 11'h000;
	localparam logic [10:0] VEC_EXT   = 11'h004;
	localparam logic [10:0] VEC_TMR   = 11'h008;
	// return stack depth
	localparam int unsigned STACK_DEPTH = 2;
	// the four instruction phases, one-hot
	typedef enum logic [3:0] {
		PH_T1 = 4'h1,
		PH_T2 = 4'h2,
		PH_T3 = 4'h4,
		PH_T4 = 4'h8
	} pss_phase_t;
	// instruction classes reported by the decoder
	typedef enum logic [2:0] {
		OP_SEQ  = 3'h0,
		OP_SKIP = 3'h1,
		OP_JUMP = 3'h2,
		OP_CALL = 3'h3,
		OP_RET  = 3'h4,
		OP_INTERRUPT_RETURN = 3'h5
	} pss_op_t;
	// command from the decoder for the executing instruction
	typedef struct packed {
		logic       valid;
		pss_op_t    op;
		logic [10:0] target;
	} pss_cmd_t;
	// interrupt request or acknowledge pair
	typedef struct packed {
		logic ext;
		logic tmr;
	} pss_irq_t;
endpackage

/* pss_phase_gen.sv */
`timescale 1ns/1ps
// four-phase divider and phase-clock pin driver
module pss_phase_gen
	import pss_pkg::*;
(
	// clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// rc oscillator option
	input  wire logic rc_sel,
	// phase outputs
	output pss_phase_t phase,
	output logic       osc_out
);
	// whole state of the divider
	typedef struct packed {
		pss_phase_t phase;
		logic       osc;
	} pss_pg_state_t;

	pss_pg_state_t s_q;  // registered state
	pss_pg_state_t s_d;  // next state

	// rotate through the phases
	always_comb begin
		s_d = s_q;
		case (s_q.phase)
			PH_T1: s_d.phase = PH_T2;
			PH_T2: s_d.phase = PH_T3;
			PH_T3: s_d.phase = PH_T4;
			PH_T4: s_d.phase = PH_T1;
			default: s_d.phase = PH_T1;
		endcase
		s_d.osc = rc_sel && (s_d.phase == PH_T1);
	end

	// state register, first cycle after reset is t1
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_q <= '{phase: PH_T1, osc: 1'b0};
		end else begin
			s_q <= s_d;
		end
	end

	assign phase   = s_q.phase;
	assign osc_out = s_q.osc;

	// one high cycle then three low
	osc_duty_a: assert property (@(posedge clk) disable iff (rst)
		osc_out |=> !osc_out [*3])
		else $error("phase clock pin duty wrong");

	phase_ring_a: assert property (@(posedge clk) disable iff (rst)
		phase == PH_T4 |=> phase == PH_T1 ##1 phase == PH_T2 ##1 phase == PH_T3)
		else $error("phase order broken");
endmodule

/* pss_top.sv */
`timescale 1ns/1ps
module pss_top
	import pss_pkg::*;
#(
	parameter int unsigned PC_W = 11
) (
	// clock and reset
	input  wire logic              clk,
	input  wire logic              rst,
	// axi4-lite write channels
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	// axi4-lite read channels
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	// decoder side
	input  wire pss_cmd_t          cmd_i,
	output logic                   exec_valid,
	output pss_phase_t             phase,
	// program memory side
	output logic [PC_W-1:0]        fetch_addr,
	output logic                   fetch_stb,
	// interrupt logic side
	input  wire pss_irq_t          irq_req,
	output pss_irq_t               irq_ack,
	// phase clock pin
	output logic                   osc_out
);
	localparam int unsigned LVL_W = $clog2(STACK_DEPTH + 1);
	localparam logic [LVL_W-1:0] LVL_FULL = LVL_W'(STACK_DEPTH);

	if (PC_W < 9 || PC_W > 11) begin : g_pcw_chk
		$error("pss_top: PC_W must be 9, 10 or 11");
	end

	// whole state of the sequencer and its slave
	typedef struct packed {
		logic [PC_W-1:0]                  pc;          // next fetch address
		logic [PC_W-1:0]                  fetch_addr;  // address fetched at t1
		logic                             fetch_stb;   // t1 fetch pulse
		logic                             fetch_ok;    // prefetch still wanted
		logic                             exec_valid;  // executing slot is real
		pss_irq_t                         irq_ack;     // acknowledge pulses
		logic [STACK_DEPTH-1:0][PC_W-1:0] stk;         // entry 0 is newest
		logic [LVL_W-1:0]                 lvl;         // filled levels
		logic                             pcl_pend;    // low-byte write waiting
		logic [7:0]                       pcl_data;    // its value
		logic [2:0]                       ctl;         // control bits
		logic                             aw_got;      // address held
		logic [ADDR_W-1:0]                aw_addr;
		logic                             w_got;       // data held
		logic [7:0]                       w_data;
		logic                             w_strb;
		logic                             awready;
		logic                             wready;
		logic                             bvalid;
		logic [1:0]                       bresp;
		logic                             arready;
		logic                             rvalid;
		logic [1:0]                       rresp;
		logic [31:0]                      rdata;
	} pss_state_t;

	pss_state_t s_q;       // registered state
	pss_state_t s_d;       // next state
	logic       take_op;   // branching class at t4
	logic       redirect;  // prefetch thrown away at t4
	logic       can_irq;   // interrupt may be acknowledged

	// phase divider, also drives the pin
	pss_phase_gen u_phase (
		.clk    (clk),
		.rst    (rst),
		.rc_sel (s_q.ctl[CTL_RC_BIT]),
		.phase  (phase),
		.osc_out(osc_out)
	);

	// sequencing, stack and register slave
	always_comb begin
		s_d           = s_q;
		s_d.fetch_stb = 1'b0;
		s_d.irq_ack   = '0;
		take_op       = 1'b0;
		redirect      = 1'b0;
		can_irq       = 1'b0;

		if (phase == PH_T1) begin
			s_d.fetch_addr = s_q.pc;
			s_d.fetch_stb  = 1'b1;
			s_d.pc         = s_q.pc + 1'b1;
			s_d.exec_valid = s_q.fetch_ok;
			s_d.fetch_ok   = 1'b1;
		end

		// execution point at t4
		if (phase == PH_T4) begin
			take_op = s_q.exec_valid && cmd_i.valid && (cmd_i.op != OP_SEQ);
			// full stack withholds the acknowledge
			// irq waits for a quiet slot and a free level
			can_irq = s_q.exec_valid && !take_op && !s_q.pcl_pend
				&& (s_q.lvl < LVL_FULL);
			if (take_op) begin
				redirect = 1'b1;
				case (cmd_i.op)
					OP_SKIP: begin
						// prefetch dropped, pc already past it
						s_d.pc = s_d.pc;
					end
					OP_JUMP: begin
						s_d.pc = cmd_i.target[PC_W-1:0];
					end
					OP_CALL: begin
						s_d.pc = cmd_i.target[PC_W-1:0];
						for (int i = STACK_DEPTH - 1; i > 0; i--) begin
							s_d.stk[i] = s_q.stk[i-1];
						end
						s_d.stk[0] = s_q.fetch_addr;
						if (s_q.lvl < LVL_FULL) begin
							s_d.lvl = s_q.lvl + 1'b1;
						end
					end
					OP_RET, OP_INTERRUPT_RETURN: begin
						s_d.pc = s_q.stk[0];
						for (int i = 0; i < STACK_DEPTH - 1; i++) begin
							s_d.stk[i] = s_q.stk[i+1];
						end
						if (s_q.lvl != '0) begin
							s_d.lvl = s_q.lvl - 1'b1;
						end
					end
					default: begin
						redirect = 1'b0;
					end
				endcase
			end else if (s_q.pcl_pend) begin
				// page bits kept, low byte replaced
				redirect     = 1'b1;
				s_d.pcl_pend = 1'b0;
				s_d.pc       = {s_q.pc[PC_W-1:8], s_q.pcl_data};
			end else if (can_irq && irq_req.ext && s_q.ctl[CTL_EXT_BIT]) begin
				redirect        = 1'b1;
				s_d.irq_ack.ext = 1'b1;
				s_d.pc          = VEC_EXT[PC_W-1:0];
			end else if (can_irq && irq_req.tmr && s_q.ctl[CTL_TMR_BIT]) begin
				redirect        = 1'b1;
				s_d.irq_ack.tmr = 1'b1;
				s_d.pc          = VEC_TMR[PC_W-1:0];
			end
			if (s_d.irq_ack.ext || s_d.irq_ack.tmr) begin
				for (int i = STACK_DEPTH - 1; i > 0; i--) begin
					s_d.stk[i] = s_q.stk[i-1];
				end
				s_d.stk[0] = s_q.fetch_addr;
				s_d.lvl    = s_q.lvl + 1'b1;
			end
			if (redirect) begin
				s_d.fetch_ok = 1'b0;
			end
		end

		// axi write: address and data in either order
		if (s_q.awready && s_axi_awvalid) begin
			s_d.aw_got  = 1'b1;
			s_d.aw_addr = s_axi_awaddr;
		end
		if (s_q.wready && s_axi_wvalid) begin
			s_d.w_got  = 1'b1;
			s_d.w_data = s_axi_wdata[7:0];
			s_d.w_strb = s_axi_wstrb[0];
		end
		if (s_q.bvalid && s_axi_bready) begin
			s_d.bvalid = 1'b0;
		end
		// commit once both halves are held; set beats the t4 clear
		if (s_d.aw_got && s_d.w_got && !s_d.bvalid) begin
			s_d.aw_got = 1'b0;
			s_d.w_got  = 1'b0;
			s_d.bvalid = 1'b1;
			s_d.bresp  = RESP_OKAY;
			case (s_d.aw_addr)
				ADDR_PCL: begin
					if (s_d.w_strb) begin
						s_d.pcl_pend = 1'b1;
						s_d.pcl_data = s_d.w_data;
					end
				end
				ADDR_CTL: begin
					if (s_d.w_strb) begin
						s_d.ctl = s_d.w_data[2:0];
					end
				end
				ADDR_STA: begin
					// read-only, write ignored
					s_d.bresp = RESP_OKAY;
				end
				default: begin
					s_d.bresp = RESP_SLVERR;
				end
			endcase
		end
		s_d.awready = !s_d.aw_got && !s_d.bvalid;
		s_d.wready  = !s_d.w_got && !s_d.bvalid;

		// axi read: one cycle to rvalid
		if (s_q.rvalid && s_axi_rready) begin
			s_d.rvalid = 1'b0;
		end
		if (s_q.arready && s_axi_arvalid) begin
			s_d.rvalid = 1'b1;
			s_d.rresp  = RESP_OKAY;
			s_d.rdata  = '0;
			case (s_axi_araddr)
				ADDR_PCL: s_d.rdata[7:0] = s_q.pc[7:0];
				ADDR_CTL: s_d.rdata[2:0] = s_q.ctl;
				ADDR_STA: begin
					s_d.rdata[PC_W-1:0]                  = s_q.pc;
					s_d.rdata[STA_EXEC_BIT]              = s_q.exec_valid;
					s_d.rdata[STA_PHASE_LSB +: 4]        = phase;
				end
				default: s_d.rresp = RESP_SLVERR;
			endcase
		end
		s_d.arready = !s_d.rvalid;
	end

	// state register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// outputs straight from flops
	assign s_axi_awready = s_q.awready;
	assign s_axi_wready  = s_q.wready;
	assign s_axi_bresp   = s_q.bresp;
	assign s_axi_bvalid  = s_q.bvalid;
	assign s_axi_arready = s_q.arready;
	assign s_axi_rdata   = s_q.rdata;
	assign s_axi_rresp   = s_q.rresp;
	assign s_axi_rvalid  = s_q.rvalid;
	assign exec_valid    = s_q.exec_valid;
	assign fetch_addr    = s_q.fetch_addr;
	assign fetch_stb     = s_q.fetch_stb;
	assign irq_ack       = s_q.irq_ack;

	// checks on the sequencing
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence redirect_s;
		phase == PH_T4 && redirect;
	endsequence
	sequence dummy_slot_s;
		!exec_valid [*4];
	endsequence

	fetch_t1_a: assert property (
		fetch_stb |-> $past(phase) == PH_T1)
		else $error("fetch outside t1");

	branch_dummy_a: assert property (
		redirect_s |-> ##2 dummy_slot_s)
		else $error("no dummy slot after redirect");

	seq_step_a: assert property (
		phase == PH_T4 && !redirect |-> ##2
		fetch_addr == PC_W'($past(fetch_addr, 2) + 1'b1))
		else $error("sequential step wrong");

	jump_load_a: assert property (
		phase == PH_T4 && take_op && cmd_i.op == OP_JUMP |-> ##2
		fetch_addr == $past(cmd_i.target[PC_W-1:0], 2))
		else $error("jump target not loaded");

	skip_two_a: assert property (
		phase == PH_T4 && take_op && cmd_i.op == OP_SKIP |-> ##2
		fetch_addr == PC_W'($past(fetch_addr, 2) + 1'b1) ##0 dummy_slot_s)
		else $error("skip did not advance by two");

	pcl_page_a: assert property (
		phase == PH_T4 && !take_op && s_q.pcl_pend |-> ##2
		fetch_addr == {$past(s_q.pc[PC_W-1:8], 2), $past(s_q.pcl_data, 2)})
		else $error("low byte jump left page");

	full_hold_a: assert property (
		(irq_ack.ext || irq_ack.tmr) |-> $past(s_q.lvl) < LVL_FULL)
		else $error("interrupt taken on full stack");

	ext_vec_a: assert property (
		irq_ack.ext |-> ##1 fetch_addr == VEC_EXT[PC_W-1:0])
		else $error("external vector wrong");

	tmr_vec_a: assert property (
		irq_ack.tmr |-> ##1 fetch_addr == VEC_TMR[PC_W-1:0])
		else $error("timer vector wrong");

	overflow_keep_a: assert property (
		phase == PH_T4 && take_op && cmd_i.op == OP_CALL && s_q.lvl == LVL_FULL
		|=> s_q.lvl == LVL_FULL && s_q.stk[1] == $past(s_q.stk[0]))
		else $error("overflow did not keep newest two");
endmodule

/* pss_mem_model.sv */
`timescale 1ns/1ps
// program memory image and held interrupt requests facing the sequencer
module pss_mem_model
	import pss_pkg::*;
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// fetch side
	input  wire logic [10:0] fetch_addr,
	input  wire logic        fetch_stb,
	output pss_cmd_t         cmd_o,
	// interrupt side
	input  wire pss_irq_t    irq_set,
	input  wire pss_irq_t    irq_ack,
	output pss_irq_t         irq_req
);
	pss_cmd_t nxt_q;       // word fetched last, runs in the next slot
	pss_irq_t req_q = '0;  // pending events, not cleared by chip reset

	// fixed program: class and target for each address
	function automatic pss_cmd_t word(input logic [10:0] a);
		case (a)
			11'h001: word = '{1'b1, OP_SKIP, 11'h000};
			11'h003: word = '{1'b1, OP_JUMP, 11'h123};
			11'h004: word = '{1'b1, OP_INTERRUPT_RETURN, 11'h000};
			11'h008: word = '{1'b1, OP_INTERRUPT_RETURN, 11'h000};
			11'h123: word = '{1'b1, OP_CALL, 11'h200};
			11'h200: word = '{1'b1, OP_CALL, 11'h300};
			11'h300: word = '{1'b1, OP_CALL, 11'h400};
			11'h401: word = '{1'b1, OP_RET, 11'h000};
			11'h301: word = '{1'b1, OP_RET, 11'h000};
			11'h201: word = '{1'b1, OP_JUMP, 11'h5f0};
			11'h5f8: word = '{1'b1, OP_JUMP, 11'h7ff};
			// everything else runs straight on
			default: word = '{1'b1, OP_SEQ, 11'h000};
		endcase
	endfunction

	// a fetched word executes one instruction cycle after its fetch
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			nxt_q <= '0;
			cmd_o <= '0;
		end else if (fetch_stb) begin
			cmd_o <= nxt_q;
			nxt_q <= word(fetch_addr);
		end
	end

	// requests stay up until acknowledged; a new event wins over the clear
	always_ff @(posedge clk) begin
		req_q.ext <= irq_set.ext | (req_q.ext & ~irq_ack.ext);
		req_q.tmr <= irq_set.tmr | (req_q.tmr & ~irq_ack.tmr);
	end
	assign irq_req = req_q;
endmodule

/* tb_top.sv */
`timescale 1ns/1ps
// bench for the program sequencer with memory and interrupt model
module tb_top
	import pss_pkg::*;
;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [3:0]  awa = '0, ara = '0;    // bus addresses
	logic [3:0]  ws = 4'h1;             // write strobes
	logic        awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
	logic        awr, wr, bv, arr, rv, exv, fstb, osc, rc_on = 1'b0;
	logic [31:0] wd = '0, rd;
	logic [1:0]  bresp, rresp;
	logic [10:0] faddr;
	logic [10:0] trace [$];              // fetched addresses since reset
	pss_phase_t  ph;
	pss_cmd_t    cmd;
	pss_irq_t    req, ack, irq_set = '0;
	int          miscompares = 0, num_checks = 0, n_ext = 0, n_tmr = 0, gap = 0, cyc = 0;

	pss_top #(.PC_W(11)) pss_top_i (
		.clk(clk), .rst(rst), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
		.s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr),
		.s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara),
		.s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rresp),
		.s_axi_rvalid(rv), .s_axi_rready(rr), .cmd_i(cmd), .exec_valid(exv), .phase(ph),
		.fetch_addr(faddr), .fetch_stb(fstb), .irq_req(req), .irq_ack(ack), .osc_out(osc));
	pss_mem_model pss_mem_model_i (.clk(clk), .rst(rst), .fetch_addr(faddr),
		.fetch_stb(fstb), .cmd_o(cmd), .irq_set(irq_set), .irq_ack(ack), .irq_req(req));

	// free-running system clock
	initial begin
		forever #4 clk = ~clk;
	end

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic close_out;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask

	// fetch trace, fetch spacing, pin and acknowledge watch, hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			miscompares++;
			close_out();
		end
		if (ack.ext === 1'b1) n_ext++;
		if (ack.tmr === 1'b1) n_tmr++;
		if (rst) gap = 0;
		else if (fstb === 1'b1) begin
			trace.push_back(faddr);
			if (gap != 0) chk("fetch spacing", 4, gap);
			gap = 1;
		end else if (gap != 0) gap++;
		if (rc_on) chk("phase pin", ph === PH_T1, osc);
	end

	// write both channels at once, drop each when taken
	task automatic axw(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		awa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		br <= 1'b1;
		do begin
			@(posedge clk);
			if (awr) awv <= 1'b0;
			if (wr) wv <= 1'b0;
		end while (bv !== 1'b1);
		r = bresp;
		br <= 1'b0;
	endtask

	task automatic axr(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		ara <= a;
		arv <= 1'b1;
		rr <= 1'b1;
		do begin
			@(posedge clk);
			if (arr) arv <= 1'b0;
		end while (rv !== 1'b1);
		d = rd;
		r = rresp;
		rr <= 1'b0;
	endtask

	task automatic do_reset;
		rst <= 1'b1;
		repeat (12) @(posedge clk);
		trace.delete();
		n_ext = 0;
		n_tmr = 0;
		rst <= 1'b0;
	endtask

	// register defaults and refused places
	task automatic t_regs;
		logic [31:0] d;
		logic [1:0]  r;
		axr(ADDR_CTL, d, r);
		chk("ctl reset", CTL_RESET, d);
		ws <= 4'h0;
		axw(ADDR_CTL, 32'h0000_0007, r);
		ws <= 4'h1;
		chk("masked write resp", RESP_OKAY, r);
		axr(ADDR_CTL, d, r);
		chk("masked write kept", CTL_RESET, d);
		axw(4'hc, 32'h0000_0001, r);
		chk("unmapped write", RESP_SLVERR, r);
		axr(4'hc, d, r);
		chk("unmapped read", RESP_SLVERR, r);
		axw(ADDR_STA, 32'h0000_0000, r);
		chk("status write", RESP_OKAY, r);
		chk("first fetch", VEC_RESET, trace[0]);
		$display("test regs done");
	endtask

	// skip, jump, nested calls past full, returns, held timer event, wrap
	task automatic t_flow;
		logic [10:0] e [33] = '{11'h000, 11'h001, 11'h002, 11'h003, 11'h004, 11'h123,
			11'h124, 11'h200, 11'h201, 11'h300, 11'h301, 11'h400, 11'h401, 11'h402, 11'h301,
			11'h302, 11'h201, 11'h202, 11'h5f0, 11'h5f1, 11'h008, 11'h009, 11'h5f1, 11'h5f2,
			11'h5f3, 11'h5f4, 11'h5f5, 11'h5f6, 11'h5f7, 11'h5f8, 11'h5f9, 11'h7ff, 11'h000};
		logic [1:0]  r;
		do_reset();
		axw(ADDR_CTL, 32'h0000_0004, r);
		// stack is full once 0x400 has been fetched
		while (trace.size() < 12) @(posedge clk);
		irq_set <= '{1'b1, 1'b1};
		@(posedge clk);
		irq_set <= '0;
		while (trace.size() < 33) @(posedge clk);
		foreach (e[i]) chk("fetch addr", e[i], trace[i]);
		chk("timer acks", 1, n_tmr);
		chk("masked ext acks", 0, n_ext);
		$display("test flow done");
	endtask

	// external event left pending, serviced once enabled
	task automatic t_ext;
		logic [10:0] e [7] = '{11'h000, 11'h001, 11'h004, 11'h005, 11'h001, 11'h002, 11'h003};
		logic [1:0]  r;
		do_reset();
		axw(ADDR_CTL, 32'h0000_0002, r);
		while (trace.size() < 7) @(posedge clk);
		foreach (e[i]) chk("ext flow", e[i], trace[i]);
		chk("ext acks", 1, n_ext);
		$display("test ext done");
	endtask

	// low byte write inside page 5 keeps the page
	task automatic t_pcl;
		logic [1:0] r;
		int         i;
		do_reset();
		while (trace.size() < 19) @(posedge clk);
		axw(ADDR_PCL, 32'h0000_0040, r);
		while (trace.size() < 30) @(posedge clk);
		i = 19;
		while (i < 29 && trace[i] === trace[i-1] + 11'h001) i++;
		chk("page jump", 11'h540, trace[i]);
		$display("test pcl done");
	endtask

	// phase pin follows the first phase while enabled
	task automatic t_osc;
		logic [1:0] r;
		axw(ADDR_CTL, 32'h0000_0001, r);
		repeat (2) @(posedge clk);
		rc_on = 1'b1;
		repeat (40) @(posedge clk);
		rc_on = 1'b0;
		$display("test osc done");
	endtask

	initial begin
		do_reset();
		t_regs();
		t_flow();
		t_ext();
		t_pcl();
		t_osc();
		close_out();
	end
endmodule
